// >>> sim/snm_status_props.sv
// checker for the status field block, watching top-level ports only
// assumes the block's defaults: flag present, spare bits 17:16 unused
`timescale 1ns/1ps
module snm_status_props (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic nmi_entry,
   input wire logic soft_reset_entry,
   input wire logic [5:0] hw_req,
   input wire logic [5:0] req_level,
   input wire logic irq_take,
   input wire logic irq_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // a read of the field word with no entry event racing it
   wire logic rd0 = reg_rd && reg_addr == 4'h0 && !nmi_entry && !soft_reset_entry;
   wire logic req_any = |hw_req || |req_level;
   a_rsv_bit_zero: assert property (reg_rdata[18] == 1'b0) else $error("bit 18 set");
   a_impl_bits_zero: assert property (reg_rdata[17:16] == 2'h0) else $error("spare set");
   a_idle_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata");
   a_nmi_sets_flag: assert property (nmi_entry ##2 rd0 |=> reg_rdata[19]) else $error("nmi");
   a_soft_clears_flag: assert property (soft_reset_entry ##2 rd0 |=> !reg_rdata[19])
      else $error("soft");
   a_field_readback: assert property (reg_wr && reg_addr == 4'h0 ##2 rd0
      |=> reg_rdata[15:10] == $past(reg_wdata[15:10], 3)) else $error("field");
   a_take_has_cause: assert property ($rose(irq_take) |-> $past(req_any) || $past(req_any, 2))
      else $error("take");
   // mask cleared and not rewritten: the level output must drop
   a_mask_off_quiet: assert property (reg_wr && reg_addr == 4'h2 && reg_wdata[2:0] == 3'h0
      ##1 !(reg_wr && reg_addr == 4'h2) |=> !irq_out) else $error("irq");
   c_nmi: cover property (nmi_entry);
   c_take: cover property ($rose(irq_take));
   c_irq: cover property ($rose(irq_out));
endmodule : snm_status_props
bind snm_status snm_status_props chk_u (.*);

// >>> sim/status_nmi_and_interrupt_mask_fields_bench.sv
// self-checking bench for the status field block
// assumes default parameters and the bound checker
`timescale 1ns/1ps
module status_nmi_and_interrupt_mask_fields_bench;
   import snm_pkg::*;
   logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, nmi_entry = 0, soft_reset_entry = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d, v;
   logic [5:0] hw_req = 6'h0, req_level = 6'h0;
   logic irq_take, irq_out, m;
   int bad_count = 0, compares = 0, cyc = 0, seed = 32'hbe892a31;
   snm_status dut_u (.*);
   always #50 ref_clk = ~ref_clk;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one-cycle strobes, released at the next edge
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      @(posedge ref_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, x};
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic ent(input logic n);
      @(posedge ref_clk);
      {nmi_entry, soft_reset_entry} <= {n, !n};
      @(posedge ref_clk);
      {nmi_entry, soft_reset_entry} <= 2'h0;
   endtask : ent
   task automatic final_report();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   function automatic logic dec(input logic e, input logic [5:0] f, h, l);
      return e ? (l > f) : |(h & f);
   endfunction : dec
   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(ADDR_STATUS_CTRL);
      chk(v, 32'h0);
      rd(4'h9);
      chk(v, 32'h0);
      // both modes in turn; every fourth pass puts the level equal to the field
      for (int i = 0; i < 24; i++) begin
         m = i[0];
         d = $random(seed) & 32'hfff7_ffff; // flag kept 0 while it reads 0
         wr(ADDR_MODE_CTRL, {31'h0, m});
         wr(ADDR_STATUS_CTRL, d);
         hw_req <= 6'($random(seed));
         req_level <= (i % 4 == 1) ? d[15:10] : 6'($random(seed));
         rd(ADDR_STATUS_CTRL);
         chk(v, d & 32'h0000_fc00);
         repeat (2) @(posedge ref_clk);
         #1 chk(irq_take, dec(m, d[15:10], hw_req, req_level));
      end
      {hw_req, req_level} <= 12'h0;
      wr(ADDR_EVT_MASK, 32'h0);
      wr(ADDR_EVT_STATUS, 32'h7);
      ent(1'b1);
      rd(ADDR_STATUS_CTRL);
      chk(v[19], 1'b1);
      rd(ADDR_EVT_STATUS);
      chk(v, 32'h1);
      chk(irq_out, 1'b0);
      wr(ADDR_EVT_MASK, 32'h1);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_out, 1'b1);
      wr(ADDR_EVT_STATUS, 32'h1);
      repeat (2) @(posedge ref_clk);
      #1 chk(irq_out, 1'b0);
      ent(1'b0);
      rd(ADDR_STATUS_CTRL);
      chk(v[19], 1'b0);
      final_report();
   end
endmodule : status_nmi_and_interrupt_mask_fields_bench

// >>> verilog/snm_irq_arb.sv
// interrupt decision: per-line enables or priority comparison
// assumes registered field and mode from the control module; hw_req and req_level come straight from its ports
`timescale 1ns/1ps
module snm_irq_arb (
   snm_irq_if.arb irq
);
   import snm_pkg::*;
   // ext mode compares levels, otherwise the field gates each line
   always_comb begin
      if (irq.ext_mode) begin
         irq.take = (irq.req_level > irq.field);
      end else begin
         irq.take = |(irq.hw_req & irq.field);
      end
   end
endmodule : snm_irq_arb

// >>> verilog/snm_irq_if.sv
// interface carrying the interrupt decision inputs and result between modules
// assumes the same processor clock on both sides
`timescale 1ns/1ps
interface snm_irq_if;
   logic [5:0] field;
   logic [5:0] hw_req;
   logic [5:0] req_level;
   logic ext_mode;
   logic take;
   modport ctrl (output field, output hw_req, output req_level, output ext_mode, input take);
   modport arb (input field, input hw_req, input req_level, input ext_mode, output take);
endinterface : snm_irq_if

// >>> verilog/snm_pkg.sv
// package for the status-register interrupt field block
// assumes one processor clock and a plain register port from privileged software
//
// Operation
// - bit 19 shows whether the latest entry through the reset vector came from a non-maskable interrupt.
// - the flag reads 0 after a soft or full reset entry and 1 after a non-maskable interrupt entry.
// - without non-maskable interrupt support the flag ignores writes and reads zero.
// - bit 18 is written as zero by software, always reads zero and resets to zero.
// - bits 17:16 are implementation dependent and read zero, ignoring writes, when unused.
// - outside external controller mode bits 15:10 enable one hardware interrupt line each.
// - with the second release and external controller mode on, bits 15:10 are a current priority level.
// - with external controller mode off, bits 15:10 return to being per-line enables.
package snm_pkg;
   localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
   localparam logic [3:0] ADDR_EVT_STATUS = 4'h1;
   localparam logic [3:0] ADDR_EVT_MASK = 4'h2;
   localparam logic [3:0] ADDR_MODE_CTRL = 4'h3;
   localparam int NMI_BIT = 19;
   localparam int RSV_BIT = 18;
   localparam int IMPL_LO = 16;
   localparam int IMPL_W = 2;
   localparam int FLD_LO = 10;
   localparam int FLD_W = 6;
   localparam int EVT_W = 3;
   localparam int EVT_NMI = 0;
   localparam int EVT_SOFT = 1;
   localparam int EVT_HW = 2;
   localparam logic [FLD_W-1:0] FLD_RESET = 6'h00;
   localparam logic [IMPL_W-1:0] IMPL_RESET = 2'h0;
   localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
   typedef enum logic [1:0] {SNM_ENTRY_NONE, SNM_ENTRY_RESET, SNM_ENTRY_NMI} snm_entry_type;
endpackage : snm_pkg

// >>> verilog/snm_status.sv
// status register bits 19..10 with reset-entry cause, enables and priority level
// assumes reset-entry events are single-cycle pulses from the core
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module snm_status #(
   parameter bit HAS_NMI = 1'b1,
   parameter bit HAS_REL2 = 1'b1,
   parameter bit HAS_IMPL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic nmi_entry,
   input wire logic soft_reset_entry,
   input wire logic [5:0] hw_req,
   input wire logic [5:0] req_level,
   output logic irq_take,
   output logic irq_out
);
   import snm_pkg::*;

   logic rst_meta;
   logic rst_sync_n;
   logic nmi_flag;
   logic [IMPL_W-1:0] impl_bits;
   logic [FLD_W-1:0] field;
   logic ext_mode_req;
   logic [EVT_W-1:0] evt_status;
   logic [EVT_W-1:0] evt_mask;
   logic [EVT_W-1:0] evt_set;
   logic [31:0] next_rdata;
   logic take_prev;
   snm_irq_if irq_bus ();

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // cause flag: full reset clears it, entry events decide it afterwards
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         nmi_flag <= 1'b0;
      end else if (!HAS_NMI) begin
         nmi_flag <= 1'b0;
      end else if (nmi_entry) begin
         nmi_flag <= 1'b1;
      end else if (soft_reset_entry) begin
         nmi_flag <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_STATUS_CTRL) begin
         // a 0-to-1 write is accepted here; software must not rely on it
         nmi_flag <= reg_wdata[NMI_BIT];
      end
   end

   // implementation bits hold writes only when present
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         impl_bits <= IMPL_RESET;
      end else if (HAS_IMPL && reg_wr && reg_addr == ADDR_STATUS_CTRL) begin
         impl_bits <= reg_wdata[IMPL_LO +: IMPL_W];
      end
   end

   // one storage for enables or level; meaning follows the mode
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         field <= FLD_RESET;
      end else if (reg_wr && reg_addr == ADDR_STATUS_CTRL) begin
         field <= reg_wdata[FLD_LO +: FLD_W];
      end
   end

   // mode select register; ignored without the second release
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ext_mode_req <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_MODE_CTRL) begin
         ext_mode_req <= reg_wdata[0] & HAS_REL2;
      end
   end

   assign irq_bus.field = field;
   assign irq_bus.hw_req = hw_req;
   assign irq_bus.req_level = req_level;
   assign irq_bus.ext_mode = ext_mode_req;

   snm_irq_arb u_arb (
      .irq(irq_bus.arb)
   );

   // event sources; irq_bus.take counts on its rising edge, one cycle before irq_take rises
   assign evt_set[EVT_NMI] = nmi_entry & HAS_NMI;
   assign evt_set[EVT_SOFT] = soft_reset_entry;
   assign evt_set[EVT_HW] = irq_bus.take & ~take_prev;

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         evt_status <= EVT_RESET;
         evt_mask <= EVT_RESET;
         take_prev <= 1'b0;
      end else begin
         take_prev <= irq_bus.take;
         if (reg_wr && reg_addr == ADDR_EVT_STATUS) begin
            evt_status <= (evt_status & ~reg_wdata[EVT_W-1:0]) | evt_set;
         end else begin
            evt_status <= evt_status | evt_set;
         end
         if (reg_wr && reg_addr == ADDR_EVT_MASK) begin
            evt_mask <= reg_wdata[EVT_W-1:0];
         end
      end
   end

   // read mux; reserved and absent bits read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (reg_addr)
         ADDR_STATUS_CTRL: begin
            next_rdata[NMI_BIT] = nmi_flag & HAS_NMI;
            next_rdata[RSV_BIT] = 1'b0;
            next_rdata[IMPL_LO +: IMPL_W] = HAS_IMPL ? impl_bits : IMPL_RESET;
            next_rdata[FLD_LO +: FLD_W] = field;
         end
         ADDR_EVT_STATUS: next_rdata[EVT_W-1:0] = evt_status;
         ADDR_EVT_MASK: next_rdata[EVT_W-1:0] = evt_mask;
         ADDR_MODE_CTRL: next_rdata[0] = ext_mode_req;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // registered outputs: read data one cycle after the strobe only
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 32'h0000_0000;
         irq_take <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
         irq_take <= irq_bus.take;
         irq_out <= |(evt_status & evt_mask);
      end
   end
endmodule : snm_status
